// file: rtl/abba_alu.sv
/*
 Accumulator datapath: binary divide, binary increment and decrement of a memory word,
 BCD add and subtract of a discrete-bit range, and the status flags they drive.
 Assumes the sequencer has resolved every operand (constant, direct or pointer word,
 bit window starting at the addressed bit) and holds the memory address for write-back.
*/
// Operation
// - Divide 32-bit accumulator by 16-bit divisor.
// - Divisor is constant or memory word.
// - Divide uses plain binary, not BCD.
// - Quotient to accumulator, remainder to stack.
// - Remainder fills 32 bits, upper bits zero.
// - Divide sets overflow when operand unusable.
// - Zero flag set when result is zero.
// - Negative flag for divide, BCD add, subtract.
// - Flags hold until same-flag instruction runs.
// - Increment adds one, writes word back.
// - Decrement subtracts one, writes word back.
// - BCD add accumulator and bit range, 32-bit.
// - BCD subtract bit range from accumulator.
// - Bit range is 1 to 32 bits.
// - BCD results replace accumulator contents.
// - Carry out of low 16 sets flag.
// - Carry out of 32 bits sets flag.
// - Borrow from low 16 sets flag.
// - Borrow from 32 bits sets flag.
// - Non-decimal nibble sets invalid BCD flag.
`timescale 1ns/100ps
`default_nettype none
`include "abba_map.svh"

module abba_alu
   import abba_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Instruction request
   input wire logic cmd_valid,
   input wire abba_op_e cmd_op,
   input wire logic [`ABBA_OPND_W-1:0] cmd_operand,
   input wire logic [`ABBA_ACC_W-1:0] bit_window,
   input wire logic [`ABBA_CNT_W-1:0] bit_count,
   // Accumulator load
   input wire logic acc_load,
   input wire logic [`ABBA_ACC_W-1:0] acc_load_value,
   // Results
   output logic busy,
   output logic done,
   output logic [`ABBA_ACC_W-1:0] acc,
   output logic [`ABBA_ACC_W-1:0] stack1,
   output logic stack1_write,
   output logic mem_wr,
   output logic [`ABBA_OPND_W-1:0] mem_wr_data,
   // Status flags
   output logic operand_overflow_flag,
   output logic zero_result_flag,
   output logic borrow16_flag,
   output logic borrow32_flag,
   output logic carry16_flag,
   output logic carry32_flag,
   output logic negative_result_flag,
   output logic invalid_bcd_flag
);

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_meta_b;
   logic rst_sync_b;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // ****************************************
   // Operand shaping
   // ****************************************
   function automatic logic [`ABBA_ACC_W-1:0] range_mask(input logic [`ABBA_CNT_W-1:0] n);
      logic [`ABBA_ACC_W:0] ones;
      ones = ({{`ABBA_ACC_W{1'b0}}, 1'b1} << n) - 33'h1;
      range_mask = (n >= `ABBA_BITS_MAX) ? {`ABBA_ACC_W{1'b1}} : ones[`ABBA_ACC_W-1:0];
   endfunction : range_mask

   abba_state_e state;
   logic take;
   logic take_div;
   logic div_start;
   logic div_done;
   logic [`ABBA_ACC_W-1:0] div_quot;
   logic [`ABBA_OPND_W-1:0] div_rem;
   logic [`ABBA_ACC_W-1:0] range_val;
   logic [`ABBA_ACC_W-1:0] bcd_res;
   logic bcd_cy16;
   logic bcd_cy32;
   logic bcd_bad;
   logic [`ABBA_OPND_W-1:0] step_res;
   logic is_bcd;
   logic is_sub;

   assign take = cmd_valid && (state == abba_st_idle);
   assign take_div = take && (cmd_op == binary_divide_op);
   assign div_start = take_div && (cmd_operand != `ABBA_WORD_RST);
   assign range_val = bit_window & range_mask(bit_count);
   assign is_sub = cmd_op == bitrange_bcd_subtract_op;
   assign is_bcd = (cmd_op == bitrange_bcd_add_op) || is_sub;
   assign step_res = (cmd_op == binary_increment_op) ? 16'(cmd_operand + 16'h0001)
                                                     : 16'(cmd_operand - 16'h0001);

   abba_divider u_divider (
      .clk(clk),
      .rst_b(rst_sync_b),
      .start(div_start),
      .dividend(acc),
      .divisor(cmd_operand),
      .done(div_done),
      .quotient(div_quot),
      .remainder(div_rem)
   );

   abba_bcd_addsub u_bcd (
      .subtract(is_sub),
      .a(acc),
      .b(range_val),
      .result(bcd_res),
      .cy16(bcd_cy16),
      .cy32(bcd_cy32),
      .invalid(bcd_bad)
   );

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         state <= abba_st_idle;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         case (state)
            abba_st_idle:
            begin
               if (div_start)
               begin
                  state <= abba_st_divide;
                  busy <= 1'b1;
               end
               else if (take)
               begin
                  done <= 1'b1;
               end
            end
            abba_st_divide:
            begin
               if (div_done)
               begin
                  state <= abba_st_idle;
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
            default:
            begin
               state <= abba_st_idle;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // Accumulator, stack and memory write-back
   // ****************************************
   always_ff @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         acc <= `ABBA_ACC_RST;
         stack1 <= `ABBA_ACC_RST;
         stack1_write <= 1'b0;
         mem_wr <= 1'b0;
         mem_wr_data <= `ABBA_WORD_RST;
      end
      else
      begin
         stack1_write <= 1'b0;
         mem_wr <= 1'b0;
         if ((state == abba_st_divide) && div_done)
         begin
            acc <= div_quot;
            stack1 <= {16'h0000, div_rem};
            stack1_write <= 1'b1;
         end
         else if (take && is_bcd)
         begin
            acc <= bcd_res;
         end
         else if (take && ((cmd_op == binary_increment_op) || (cmd_op == binary_decrement_op)))
         begin
            mem_wr <= 1'b1;
            mem_wr_data <= step_res;
         end
         else if ((state == abba_st_idle) && !cmd_valid && acc_load)
         begin
            acc <= acc_load_value;
         end
      end
   end

   // ****************************************
   // Status flags
   // ****************************************
   always_ff @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         operand_overflow_flag <= 1'b0;
         zero_result_flag <= 1'b0;
         negative_result_flag <= 1'b0;
      end
      else if ((state == abba_st_divide) && div_done)
      begin
         operand_overflow_flag <= 1'b0;
         zero_result_flag <= div_quot == `ABBA_ACC_RST;
         negative_result_flag <= div_quot[`ABBA_ACC_W-1];
      end
      else if (take_div && !div_start)
      begin
         operand_overflow_flag <= 1'b1;
         zero_result_flag <= acc == `ABBA_ACC_RST;
         negative_result_flag <= acc[`ABBA_ACC_W-1];
      end
      else if (take && is_bcd)
      begin
         zero_result_flag <= bcd_res == `ABBA_ACC_RST;
         negative_result_flag <= bcd_res[`ABBA_ACC_W-1];
      end
      else if (take && !take_div)
      begin
         zero_result_flag <= step_res == `ABBA_WORD_RST;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         carry16_flag <= 1'b0;
         carry32_flag <= 1'b0;
         borrow16_flag <= 1'b0;
         borrow32_flag <= 1'b0;
         invalid_bcd_flag <= 1'b0;
      end
      else if (take && is_bcd)
      begin
         invalid_bcd_flag <= bcd_bad;
         if (is_sub)
         begin
            borrow16_flag <= bcd_cy16;
            borrow32_flag <= bcd_cy32;
         end
         else
         begin
            carry16_flag <= bcd_cy16;
            carry32_flag <= bcd_cy32;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   logic [`ABBA_ACC_W-1:0] chk_dividend;
   logic [`ABBA_OPND_W-1:0] chk_divisor;

   always_ff @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         chk_dividend <= `ABBA_ACC_RST;
         chk_divisor <= `ABBA_WORD_RST;
      end
      else if (div_start)
      begin
         chk_dividend <= acc;
         chk_divisor <= cmd_operand;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_b);

   a_div_result: assert property (stack1_write |-> (acc == chk_dividend / {16'h0000, chk_divisor}) &&
      (stack1 == chk_dividend % {16'h0000, chk_divisor}))
      else $error("divide quotient or remainder wrong");
   a_div_latency: assert property (div_start |-> ##[33:34] (done && stack1_write))
      else $error("divide did not finish in time");
   a_div_zero_ovf: assert property (take_div && !div_start |=> operand_overflow_flag && done && !stack1_write)
      else $error("zero divisor not flagged");
   a_inc_writeback: assert property (take && cmd_op == binary_increment_op |=>
      mem_wr && mem_wr_data == 16'($past(cmd_operand) + 16'h0001))
      else $error("increment write-back wrong");
   a_dec_writeback: assert property (take && cmd_op == binary_decrement_op |=>
      mem_wr && mem_wr_data == 16'($past(cmd_operand) - 16'h0001) && zero_result_flag == (mem_wr_data == 16'h0000))
      else $error("decrement write-back wrong");
   a_bcd_flags: assert property (take && is_bcd |=> zero_result_flag == (acc == 32'h0) &&
      negative_result_flag == acc[31] && invalid_bcd_flag == $past(bcd_bad))
      else $error("BCD result flags wrong");
   a_carry_hold: assert property (!(take && cmd_op == bitrange_bcd_add_op) |=> $stable(carry16_flag) &&
      $stable(carry32_flag))
      else $error("carry flag changed without add");
   a_borrow_set: assert property (take && is_sub |=> borrow32_flag == $past(bcd_cy32) &&
      borrow16_flag == $past(bcd_cy16))
      else $error("borrow flags wrong");
   a_write_done: assert property ((mem_wr || stack1_write) |-> done)
      else $error("result written without completion");

endmodule : abba_alu
`default_nettype wire

// file: rtl/abba_map.svh
/*
 Widths, counts and reset values of the accumulator binary and BCD datapath.
 Assumes it is included by its bare name from the rtl folder.
*/
`ifndef ABBA_MAP_SVH
`define ABBA_MAP_SVH

// ****************************************
// Widths
// ****************************************
`define ABBA_ACC_W 32
`define ABBA_OPND_W 16
`define ABBA_CNT_W 6
`define ABBA_DIGITS 8
`define ABBA_LOW_DIGITS 4

// ****************************************
// Counts and reset values
// ****************************************
`define ABBA_DIV_STEPS 6'd32
`define ABBA_BITS_MAX 6'd32
`define ABBA_ACC_RST 32'h0000_0000
`define ABBA_WORD_RST 16'h0000

`endif

// file: rtl/abba_pkg.sv
/*
 Types of the accumulator binary and BCD datapath: instruction codes and sequencer states.
 Assumes nothing of its surroundings.
*/
package abba_pkg;

   // ****************************************
   // Instructions
   // ****************************************
   typedef enum logic [2:0] {
      binary_divide_op,
      binary_increment_op,
      binary_decrement_op,
      bitrange_bcd_add_op,
      bitrange_bcd_subtract_op
   } abba_op_e;

   // ****************************************
   // States
   // ****************************************
   typedef enum logic [0:0] {
      abba_st_idle,
      abba_st_divide
   } abba_state_e;

endpackage : abba_pkg

// file: rtl/abba_divider.sv
/*
 Restoring binary divider, 32-bit dividend by 16-bit divisor, one quotient bit per clock.
 Assumes a nonzero divisor and a start pulse only while it is not running.
*/
`timescale 1ns/100ps
`default_nettype none
`include "abba_map.svh"

module abba_divider
   import abba_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Request
   input wire logic start,
   input wire logic [`ABBA_ACC_W-1:0] dividend,
   input wire logic [`ABBA_OPND_W-1:0] divisor,
   // Answer
   output logic done,
   output logic [`ABBA_ACC_W-1:0] quotient,
   output logic [`ABBA_OPND_W-1:0] remainder
);

   logic running;
   logic [`ABBA_CNT_W-1:0] steps;
   logic [`ABBA_OPND_W-1:0] dvsr;
   logic [`ABBA_OPND_W:0] trial;
   logic fits;

   // ****************************************
   // Step
   // ****************************************
   assign trial = {remainder, quotient[`ABBA_ACC_W-1]};
   assign fits = trial >= {1'b0, dvsr};

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         running <= 1'b0;
         steps <= 6'h00;
         dvsr <= `ABBA_WORD_RST;
         quotient <= `ABBA_ACC_RST;
         remainder <= `ABBA_WORD_RST;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            running <= 1'b1;
            steps <= `ABBA_DIV_STEPS;
            dvsr <= divisor;
            quotient <= dividend;
            remainder <= `ABBA_WORD_RST;
         end
         else if (running)
         begin
            if (fits)
            begin
               remainder <= 16'(trial - {1'b0, dvsr});
            end
            else
            begin
               remainder <= trial[`ABBA_OPND_W-1:0];
            end
            quotient <= {quotient[`ABBA_ACC_W-2:0], fits};
            steps <= steps - 6'h01;
            if (steps == 6'h01)
            begin
               running <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

endmodule : abba_divider
`default_nettype wire

// file: rtl/abba_bcd_addsub.sv
/*
 Combinational eight-digit BCD adder and subtractor with digit-4 and digit-8 carry or borrow.
 Assumes both operands are presented at full width; invalid digits are reported, not corrected.
*/
`timescale 1ns/100ps
`default_nettype none
`include "abba_map.svh"

module abba_bcd_addsub
   import abba_pkg::*;
(
   // Operands
   input wire logic subtract,
   input wire logic [`ABBA_ACC_W-1:0] a,
   input wire logic [`ABBA_ACC_W-1:0] b,
   // Result
   output logic [`ABBA_ACC_W-1:0] result,
   output logic cy16,
   output logic cy32,
   output logic invalid
);

   function automatic logic bad_digit(input logic [3:0] d);
      bad_digit = d > 4'h9;
   endfunction : bad_digit

   logic [`ABBA_DIGITS:0] cy;
   logic [`ABBA_DIGITS-1:0] bad;

   // ****************************************
   // Digit chain
   // ****************************************
   assign cy[0] = 1'b0;

   for (genvar i = 0; i < `ABBA_DIGITS; i++)
   begin : g_digit
      logic [3:0] da;
      logic [3:0] db;
      logic [4:0] raw;
      logic [4:0] fixed;
      assign da = a[4*i+3:4*i];
      assign db = b[4*i+3:4*i];
      assign raw = subtract ? ({1'b0, da} - {1'b0, db} - {4'h0, cy[i]})
                            : ({1'b0, da} + {1'b0, db} + {4'h0, cy[i]});
      assign cy[i+1] = subtract ? raw[4] : (raw > 5'h09);
      assign fixed = subtract ? (raw + 5'h0a) : (raw + 5'h06);
      assign result[4*i+3:4*i] = cy[i+1] ? fixed[3:0] : raw[3:0];
      assign bad[i] = bad_digit(da) | bad_digit(db);
   end

   assign cy16 = cy[`ABBA_LOW_DIGITS];
   assign cy32 = cy[`ABBA_DIGITS];
   assign invalid = |bad;

endmodule : abba_bcd_addsub
`default_nettype wire

// file: tb/abba_seq_model.sv
/*
 Operand memory of the sequencer: eight data words, read by address, written back on mem_wr.
 Assumes the bench holds the address from request to write-back.
*/
`timescale 1ns/100ps
`default_nettype none

module abba_seq_model
(
   // Clock
   input wire logic clk,
   // Access
   input wire logic [2:0] addr,
   input wire logic mem_wr,
   input wire logic [15:0] mem_wr_data,
   output logic [15:0] rd_word
);
   logic [15:0] mem [0:7] = '{16'hffff, 16'h0000, 16'h0007, 16'h0003, 16'h1234, 16'h0100, 16'h8000, 16'h00ff};

   always @(posedge clk)
   begin
      if (mem_wr)
      begin
         mem[addr] <= mem_wr_data;
      end
   end

   assign rd_word = mem[addr];
endmodule : abba_seq_model
`default_nettype wire

// file: tb/test_accumulator_binary_bcd_alu.sv
/*
 Self-checking bench of the accumulator datapath: a driver notes expectations, a monitor checks them.
 Assumes the design and its package are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module test_accumulator_binary_bcd_alu
   import abba_pkg::*;
;
   typedef struct {logic [31:0] acc; logic [31:0] stk; logic [15:0] mem; logic [9:0] flg; int when; bit ca;} abba_exp_s;
   logic clk = 0, rst_b = 0, cmd_valid = 0, acc_load = 0;
   abba_op_e cmd_op = binary_divide_op;
   logic [15:0] cmd_operand = 0, mem_wr_data, rd_word;
   logic [31:0] bit_window = 0, acc_load_value = 0, acc, stack1;
   logic [5:0] bit_count = 0;
   logic busy, done, stack1_write, mem_wr;
   logic [7:0] flags;
   logic [2:0] addr = 0;
   logic [31:0] m_acc = 0, m_stk = 0;
   logic [15:0] m_mem = 0;
   logic [7:0] m_flg = 0;
   int err_count = 0, tests_run = 0, cyc = 0, seed = 43;
   abba_exp_s q[$];

   abba_alu i_abba_alu (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_operand(cmd_operand), .bit_window(bit_window), .bit_count(bit_count), .acc_load(acc_load),
      .acc_load_value(acc_load_value), .busy(busy), .done(done), .acc(acc), .stack1(stack1),
      .stack1_write(stack1_write), .mem_wr(mem_wr), .mem_wr_data(mem_wr_data),
      .operand_overflow_flag(flags[7]), .zero_result_flag(flags[6]), .borrow16_flag(flags[5]),
      .borrow32_flag(flags[4]), .carry16_flag(flags[3]), .carry32_flag(flags[2]),
      .negative_result_flag(flags[1]), .invalid_bcd_flag(flags[0]));
   abba_seq_model i_abba_seq_model (.clk(clk), .addr(addr), .mem_wr(mem_wr), .mem_wr_data(mem_wr_data),
      .rd_word(rd_word));

   initial
   begin
      forever #50 clk = ~clk;
   end

   always @(posedge clk) cyc <= cyc + 1;

   // ****************************************
   // Comparisons and expected values
   // ****************************************
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   task automatic bad(input string msg);
      err_count++;
      $display("BAD %0t %s", $time, msg);
   endtask : bad

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) bad($sformatf("word %h expected %h", got, exp));
   endtask : cmp_word

   task automatic cmp_half(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) bad($sformatf("half %h expected %h", got, exp));
   endtask : cmp_half

   task automatic cmp_flags(input logic [9:0] got, input logic [9:0] exp);
      tests_run++;
      if (got !== exp) bad($sformatf("flags %b expected %b", got, exp));
   endtask : cmp_flags

   function automatic logic [34:0] bcd(input logic sub, input logic [31:0] a, input logic [31:0] b);
      int d;
      logic c, c16, inv;
      logic [31:0] r;
      c = 0;
      c16 = 0;
      inv = 0;
      r = 0;
      for (int i = 0; i < 8; i++)
      begin
         if (a[i*4+:4] > 4'h9 || b[i*4+:4] > 4'h9) inv = 1;
         d = sub ? int'(a[i*4+:4]) - int'(b[i*4+:4]) - int'(c) : int'(a[i*4+:4]) + int'(b[i*4+:4]) + int'(c);
         c = sub ? (d < 0) : (d > 9);
         if (c) d = sub ? d + 10 : d - 10;
         r[i*4+:4] = d[3:0];
         if (i == 3) c16 = c;
      end
      return {inv, c, c16, r};
   endfunction : bcd

   function automatic logic [31:0] rbcd();
      logic [31:0] r;
      for (int i = 0; i < 8; i++) r[i*4+:4] = 4'({$random(seed)} % 10);
      return r;
   endfunction : rbcd

   // ****************************************
   // Driver
   // ****************************************
   task automatic wait_idle;
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 100)
      begin
         cmd_valid = 0;
         acc_load = 1;
         acc_load_value = $random(seed);
         @(negedge clk);
         k++;
      end
      if (k == 100) bad("busy never fell");
      if (k == 100) wrap_up();
   endtask : wait_idle

   task automatic load(input logic [31:0] v);
      wait_idle();
      cmd_valid = 0;
      acc_load = 1;
      acc_load_value = v;
      m_acc = v;
      @(negedge clk);
   endtask : load

   task automatic idle;
      cmd_valid = 0;
      acc_load = 0;
      @(negedge clk);
   endtask : idle

   task automatic issue(input abba_op_e op, input logic [15:0] opd, input logic [31:0] win, input logic [5:0] cnt);
      abba_exp_s e;
      logic [34:0] r;
      logic sub;
      int lat;
      wait_idle();
      cmd_valid = 1;
      cmd_op = op;
      cmd_operand = opd;
      bit_window = win;
      bit_count = cnt;
      acc_load = $random(seed);
      acc_load_value = $random(seed);
      e.ca = 1;
      lat = 1;
      e.flg[9:8] = 2'b00;
      sub = (op == bitrange_bcd_subtract_op);
      if (op == binary_divide_op)
      begin
         m_flg[7] = (opd == 16'h0000);
         if (opd != 16'h0000) m_stk = {16'h0000, 16'(m_acc % opd)};
         if (opd != 16'h0000) m_acc = m_acc / opd;
         if (opd != 16'h0000) e.flg[8] = 1;
         if (opd != 16'h0000) lat = 34;
         m_flg[6] = (m_acc == 0);
         m_flg[1] = m_acc[31];
      end
      else if (op == binary_increment_op || op == binary_decrement_op)
      begin
         m_mem = (op == binary_increment_op) ? opd + 16'h0001 : opd - 16'h0001;
         m_flg[6] = (m_mem == 16'h0000);
         e.flg[9] = 1;
      end
      else
      begin
         r = bcd(sub, m_acc, (cnt >= 6'd32) ? win : win & ((32'h1 << cnt) - 32'h1));
         m_acc = r[31:0];
         m_flg[6] = (m_acc == 0);
         m_flg[1] = m_acc[31];
         m_flg[0] = r[34];
         e.ca = !r[34];
         if (sub) m_flg[5:4] = {r[32], r[33]};
         else m_flg[3:2] = {r[32], r[33]};
      end
      e.acc = m_acc;
      e.stk = m_stk;
      e.mem = m_mem;
      e.flg[7:0] = m_flg;
      e.when = cyc + lat;
      q.push_back(e);
      @(negedge clk);
   endtask : issue

   // ****************************************
   // Monitor
   // ****************************************
   always @(negedge clk)
   begin
      if (rst_b === 1'b1 && done === 1'b1)
      begin
         if (q.size() == 0)
            bad("unexpected completion");
         else
         begin
            if (q[0].ca) cmp_word(acc, q[0].acc);
            cmp_word(stack1, q[0].stk);
            cmp_half(16'(busy), 16'h0000);
            cmp_half(mem_wr_data, q[0].mem);
            cmp_flags({mem_wr, stack1_write, flags}, q[0].flg);
            cmp_half(16'(cyc), 16'(q[0].when));
            void'(q.pop_front());
         end
      end
   end

   initial
   begin
      int k;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst_b = 1;
      repeat (4) @(negedge clk);
      load(32'h00ff_ffff);
      issue(binary_divide_op, 16'h0007, 0, 0);
      issue(binary_divide_op, 16'h0000, 0, 0);
      load(32'hffff_ffff);
      issue(binary_divide_op, 16'h0001, 0, 0);
      issue(binary_divide_op, 16'hffff, 0, 0);
      load(32'h0000_0005);
      addr = 3'd2;
      idle();
      issue(binary_divide_op, rd_word, 0, 0);
      for (int a = 0; a < 3; a++)
      begin
         addr = 3'(a);
         idle();
         issue(binary_increment_op, rd_word, 0, 0);
         idle();
         issue(binary_decrement_op, rd_word, 0, 0);
         idle();
      end
      load(32'h0000_9999);
      issue(bitrange_bcd_add_op, 0, 32'h1, 6'd1);
      load(32'h9999_9999);
      issue(bitrange_bcd_add_op, 0, 32'h1, 6'd32);
      load(32'h0000_0000);
      issue(bitrange_bcd_subtract_op, 0, 32'h1, 6'd5);
      issue(bitrange_bcd_add_op, 0, 32'hffff_fff3, 6'd2);
      issue(bitrange_bcd_add_op, 0, 32'h0000_000a, 6'd4);
      for (int n = 0; n < 30; n++)
      begin
         load(rbcd());
         issue(($random(seed) & 1) ? bitrange_bcd_add_op : bitrange_bcd_subtract_op, 0, rbcd(),
            6'(1 + {$random(seed)} % 32));
         issue(bitrange_bcd_subtract_op, 0, rbcd(), 6'(1 + {$random(seed)} % 32));
      end
      idle();
      k = 0;
      while (q.size() > 0 && k < 100)
      begin
         idle();
         k++;
      end
      if (q.size() > 0) bad("completions missing");
      wrap_up();
   end
endmodule : test_accumulator_binary_bcd_alu
`default_nettype wire
